/* File: hw/sid_map.vh */
// constants for the serial id two-wire slave
// Contract
// - bytes msb first, then one ack slot
// - start: data falls while clock high
// - stop: data rises while clock high
// - repeated start handled like start
// - data change with clock high is condition
// - receive samples data on clock rise
// - transmit drives bit after clock fall
// - master clocks all; slave never stretches
// - always acknowledge own slave address
// - ack holds data low ninth pulse
// - master nack ends read; slave releases
// - first write byte loads pointer
// - ack pointer bytes 00h to 08h only
// - rom writes discarded and not acknowledged
// - pointer advances after write, wraps
// - read starts at current pointer
// - pointer resets to 00h
// - pointer advances per read byte, wraps
// - timeout reset keeps the pointer
// - eight rom bytes plus control byte
// - control keeps bit 0 only
// - mode bit enables stuck-bus timeout
// - rom: family, serial lsb first, crc
// - address lsb gives direction
`ifndef SID_MAP_VH
`define SID_MAP_VH
`define SID_LAST_LOC      4'h8
`define SID_CTRL_LOC      4'h8
`define SID_PTR_RESET     4'h0
`define SID_MODE_RESET    1'b1
`define SID_TIMEOUT_MS    25
`define SID_CLK_KHZ       200000
`define SID_TIMEOUT_CYC   (`SID_TIMEOUT_MS * `SID_CLK_KHZ)
`endif

/* File: hw/sid_i2c_slave.v */
// two-wire serial id slave: 8 rom bytes and one control byte
`include "sid_map.vh"

module sid_i2c_slave #(
    parameter [6:0]  SLAVE_ADDR  = 7'h50,     // arbitrary default
    parameter [7:0]  FAMILY_CODE = 8'h5a,     // arbitrary value
    parameter [47:0] SERIAL_NUM  = 48'h0123456789ab, // arbitrary value
    parameter [31:0] TIMEOUT_CYC = `SID_TIMEOUT_CYC
) (
    input  wire       mclk,
    input  wire       rst,
    input  wire       sclIn,
    input  wire       sdaIn,
    output wire       sdaOut,
    output wire       sdaOe,
    output wire       smbusModeSelect,
    output wire [3:0] pointerValue,
    output wire       busBusy
);

// ----------------------------------------------------------------
// line synchronisers and edge detection
// ----------------------------------------------------------------
// index 0 is the clock line, index 1 the data line
wire [1:0] pinIn = {sdaIn, sclIn};
wire [1:0] pinSync;                // second synchroniser flop
wire [1:0] pinDly;                 // one cycle later, for edges

// both pins are asynchronous to mclk; each passes two flops and
// only the second one is read onward, so metastability cannot
// reach the protocol logic
genvar g;
generate
    for (g = 0; g < 2; g = g + 1)
    begin : gLineSync
        reg [1:0] sync_reg;
        reg       dly_reg;

        // reset to the idle level so no false edge follows reset
        always @(posedge mclk or posedge rst)
        begin
            if (rst)
            begin
                sync_reg <= 2'h3;
                dly_reg  <= 1'b1;
            end
            else
            begin
                sync_reg <= {sync_reg[0], pinIn[g]};
                dly_reg  <= sync_reg[1];
            end
        end

        assign pinSync[g] = sync_reg[1];
        assign pinDly[g]  = dly_reg;
    end
endgenerate

wire scl     = pinSync[0];
wire sda     = pinSync[1];
wire sclDly  = pinDly[0];
wire sdaDly  = pinDly[1];
wire sclRise = scl & ~sclDly;
wire sclFall = ~scl & sclDly;
// any data move while clock high is a condition; the clock must be
// high on two samples so a data change on the same sample as a clock
// rise is never taken for one
wire startDet = scl & sclDly & sdaDly & ~sda;
wire stopDet  = scl & sclDly & ~sdaDly & sda;

// ----------------------------------------------------------------
// rom contents
// ----------------------------------------------------------------
// crc x^8+x^5+x^4+1, lsb first, over family and serial
function [7:0] crc56;
    input [55:0] d;
    integer i;
    reg [7:0] c;
    reg       fb;
    begin
        c = 8'h00;
        for (i = 0; i < 56; i = i + 1)
        begin
            fb = c[0] ^ d[i];
            c = {1'b0, c[7:1]};
            if (fb)
                c = c ^ 8'h8c;
        end
        crc56 = c;
    end
endfunction

localparam [55:0] ROM_LOW = {SERIAL_NUM, FAMILY_CODE};
localparam [7:0]  ROM_CRC = crc56(ROM_LOW);
// fixed at elaboration: no bus write can ever reach the rom
wire [63:0] romImage = {ROM_CRC, ROM_LOW};

// ----------------------------------------------------------------
// protocol state machine
// ----------------------------------------------------------------
localparam [2:0] ST_IDLE = 3'h0;   // waiting for start
localparam [2:0] ST_ADDR = 3'h1;   // shifting slave address
localparam [2:0] ST_PTR  = 3'h2;   // shifting pointer byte
localparam [2:0] ST_WDAT = 3'h3;   // shifting write data
localparam [2:0] ST_RDAT = 3'h4;   // sending read data
localparam [2:0] ST_ACK  = 3'h5;   // slave ack slot
localparam [2:0] ST_MACK = 3'h6;   // master ack slot

reg [2:0]  state_reg;
reg [2:0]  after_reg;              // state after our ack slot
reg [3:0]  bitCnt_reg;
reg [7:0]  shift_reg;
reg [3:0]  ptr_reg;
reg        mode_reg;
reg        drvLow_reg;
reg        ackNow_reg;             // ack decided for this slot
reg [31:0] toCnt_reg;

// received byte with the current bit appended
wire [7:0] rxByte = {shift_reg[6:0], sda};
wire [7:0] locByte = (ptr_reg == `SID_CTRL_LOC) ? {7'h00, mode_reg}
                   : romImage[{ptr_reg[2:0], 3'h0} +: 8];
// one increment shared by the read and write paths
wire [3:0] ptrInc = (ptr_reg == `SID_LAST_LOC) ? `SID_PTR_RESET
                  : ptr_reg + 4'h1;

// ----------------------------------------------------------------
// bus timeout
// ----------------------------------------------------------------
// the bus shows life when the data line is high at a clock edge or
// the bus sits idle; a clock stuck low, or a data line
// held low even while the clock runs, lets the count climb
wire sclMoved = sclRise | sclFall;
wire busAlive = sda & (sclMoved | scl);
wire toHit    = mode_reg & (toCnt_reg >= TIMEOUT_CYC - 32'h1);

// the count is held at zero while the timeout is disabled so it
// never wraps; the limit is far longer than any legal low data run
always @(posedge mclk or posedge rst)
begin
    if (rst)
        toCnt_reg <= 32'h0;
    else if (busAlive || toHit || !mode_reg)
        toCnt_reg <= 32'h0;
    else
        toCnt_reg <= toCnt_reg + 32'h1;
end

// main sequencing; ack and data only change after a clock fall, so
// the line is steady over every high clock phase, and a condition
// or a timeout overrides whatever state the transfer is in
always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        state_reg  <= ST_IDLE;
        after_reg  <= ST_IDLE;
        bitCnt_reg <= 4'h0;
        shift_reg  <= 8'h00;
        ptr_reg    <= `SID_PTR_RESET;
        mode_reg   <= `SID_MODE_RESET;
        drvLow_reg <= 1'b0;
        ackNow_reg <= 1'b0;
    end
    else if (toHit || stopDet)
    begin
        // timeout acts as stop; pointer left alone
        state_reg  <= ST_IDLE;
        drvLow_reg <= 1'b0;
    end
    else if (startDet)
    begin
        // a start aborts any transfer and re-arms the address phase
        state_reg  <= ST_ADDR;
        bitCnt_reg <= 4'h0;
        drvLow_reg <= 1'b0;
    end
    else
    begin
        case (state_reg)
            ST_ADDR, ST_PTR, ST_WDAT:
            begin
                if (sclRise)
                begin
                    shift_reg  <= rxByte;
                    bitCnt_reg <= bitCnt_reg + 4'h1;
                end
                // eighth bit in: settle the ack before the ninth pulse
                else if (sclFall && bitCnt_reg == 4'h8)
                begin
                    bitCnt_reg <= 4'h0;
                    if (state_reg == ST_ADDR)
                    begin
                        if (shift_reg[7:1] == SLAVE_ADDR)
                        begin
                            drvLow_reg <= 1'b1;
                            after_reg  <= shift_reg[0] ? ST_RDAT
                                        : ST_PTR;
                            state_reg  <= ST_ACK;
                        end
                        else
                            state_reg <= ST_IDLE;
                    end
                    else if (state_reg == ST_PTR)
                    begin
                        state_reg <= ST_ACK;
                        after_reg <= ST_WDAT;
                        // beyond the last location: no ack, old pointer
                        if (shift_reg <= {4'h0, `SID_LAST_LOC})
                        begin
                            ptr_reg    <= shift_reg[3:0];
                            drvLow_reg <= 1'b1;
                        end
                    end
                    else
                    begin
                        state_reg <= ST_ACK;
                        after_reg <= ST_WDAT;
                        // rom locations store nothing and get no ack
                        if (ptr_reg == `SID_CTRL_LOC)
                        begin
                            mode_reg   <= shift_reg[0];
                            drvLow_reg <= 1'b1;
                        end
                        ptr_reg <= ptrInc;
                    end
                end
            end
            ST_ACK:
            begin
                // release after ninth pulse, then first read bit
                // the pointer moves as each read byte is loaded
                if (sclFall)
                begin
                    state_reg  <= after_reg;
                    bitCnt_reg <= 4'h0;
                    if (after_reg == ST_RDAT)
                    begin
                        shift_reg  <= {locByte[6:0], 1'b0};
                        drvLow_reg <= ~locByte[7];
                        ptr_reg    <= ptrInc;
                    end
                    else
                        drvLow_reg <= 1'b0;
                end
            end
            ST_RDAT:
            begin
                if (sclFall)
                begin
                    bitCnt_reg <= bitCnt_reg + 4'h1;
                    // eighth fall: free the line for the master's ack
                    if (bitCnt_reg == 4'h7)
                    begin
                        drvLow_reg <= 1'b0;                // release for ack
                        state_reg  <= ST_MACK;
                    end
                    else
                    begin
                        drvLow_reg <= ~shift_reg[7];
                        shift_reg  <= {shift_reg[6:0], 1'b0};
                    end
                end
            end
            ST_MACK:
            begin
                // master ack is sampled while the clock is high
                if (sclRise)
                    ackNow_reg <= ~sda;
                else if (sclFall)
                begin
                    if (ackNow_reg)
                    begin
                        state_reg  <= ST_RDAT;
                        bitCnt_reg <= 4'h0;
                        shift_reg  <= {locByte[6:0], 1'b0};
                        drvLow_reg <= ~locByte[7];
                        ptr_reg    <= ptrInc;
                    end
                    else
                        state_reg <= ST_IDLE;
                end
            end
            // wait for a start; a foreign address also lands here
            ST_IDLE:
                drvLow_reg <= 1'b0;
            default:
                state_reg <= ST_IDLE;
        endcase
    end
end

// ----------------------------------------------------------------
// pin drive and status
// ----------------------------------------------------------------
// open drain: only ever pull low; the clock pin has no driver at
// all, so the master never sees it stretched
assign sdaOut          = 1'b0;
assign sdaOe           = drvLow_reg;
assign smbusModeSelect = mode_reg;
assign pointerValue    = ptr_reg;
assign busBusy         = (state_reg != ST_IDLE);

endmodule // sid_i2c_slave

/* File: verification/sid_i2c_slave_properties.sv */
// assertion checker for the serial id two-wire slave
module sid_i2c_slave_properties (
    input wire       mclk,
    input wire       rst,
    input wire       sclIn,
    input wire       sdaIn,
    input wire       sdaOut,
    input wire       sdaOe,
    input wire       smbusModeSelect,
    input wire [3:0] pointerValue,
    input wire       busBusy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    open_drain_a: assert property (sdaOut == 1'b0)
        else $error("data pin driven high");
    drive_low_clk_a: assert property ($rose(sdaOe) |-> !sclIn)
        else $error("data pulled while clock high");
    hold_high_a: assert property (sclIn && $past(sclIn, 4) |-> $stable(sdaOe))
        else $error("data moved during clock high");
    reset_vals_a: assert property ($fell(rst) |-> smbusModeSelect
        && pointerValue == 4'h0)
        else $error("bad values after reset");
    ptr_range_a: assert property (pointerValue <= 4'h8)
        else $error("pointer beyond last location");
    // idle means nothing moves: pointer stable after two idle samples, not at the timeout itself
    idle_ptr_a: assert property (!busBusy && !$past(busBusy)
        |-> $stable(pointerValue))
        else $error("pointer moved while idle");
    idle_rel_a: assert property (!busBusy && !$past(busBusy) |-> !sdaOe)
        else $error("data held while idle");
    mode_busy_a: assert property ($changed(smbusModeSelect) |-> busBusy)
        else $error("mode changed outside transfer");
    start_seen_a: assert property ($fell(sdaIn) && sclIn
        |-> ##[1:8] busBusy)
        else $error("start not seen");
    stop_seen_a: assert property ($rose(sdaIn) && sclIn
        |-> ##[1:8] !busBusy)
        else $error("stop not seen");
    cover property ($rose(sdaOe));
    cover property ($changed(smbusModeSelect));
    cover property ($fell(busBusy) && pointerValue == 4'h3);
endmodule // sid_i2c_slave_properties

bind sid_i2c_slave sid_i2c_slave_properties u_chk (.mclk, .rst, .sclIn,
    .sdaIn, .sdaOut, .sdaOe, .smbusModeSelect, .pointerValue, .busBusy);

/* File: verification/sid_host_model.sv */
// bus master model driving the two-wire lines, 80 ns bit period
module sid_host_model (
    input wire         mclk,
    input wire         sda,
    output logic       scl,
    output logic       sdaDrv,
    output logic [8:0] obs
);
    timeunit 1ns;
    timeprecision 1ps;
    event done;
    initial
    begin
        scl = 1'b1;
        sdaDrv = 1'b1;
        obs = 9'h0;
    end
    // start or repeated start; only entered with bus idle or clock low
    task start;
        @(negedge mclk) sdaDrv = 1'b1;
        #20 scl = 1'b1;
        #40 sdaDrv = 1'b0;
        #40 scl = 1'b0;
        #20;
    endtask
    // byte msb first plus ack slot; clock never waits for the slave
    task xfer(input logic [7:0] d, input logic ack);
        integer i;
        for (i = 8; i >= 0; i--)
        begin
            @(negedge mclk) sdaDrv = (i > 0) ? d[i-1] : ack;
            #20 scl = 1'b1;
            #20 obs[i] = sda;
            #20 scl = 1'b0;
            #20;
        end
        -> done;
    endtask
    task stop;
        @(negedge mclk) sdaDrv = 1'b0;
        #20 scl = 1'b1;
        #40 sdaDrv = 1'b1;
        #40;
    endtask
endmodule // sid_host_model

/* File: verification/sid_i2c_slave_tb.sv */
// self-checking bench for the serial id two-wire slave
module sid_i2c_slave_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [7:0]  FAM = 8'h3c; // arbitrary value
    localparam [47:0] SER = 48'ha1b2c3d4e5f6;
    localparam [55:0] ROMW = {SER, FAM};
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    wire        scl, sdaDrv, sdaOut, sdaOe, mode, busy;
    wire  [3:0] ptr;
    wire  [8:0] obs;
    wire        sda = sdaDrv & (sdaOe ? sdaOut : 1'b1); // wired and
    logic [8:0] expQ[$];
    integer     num_errors = 0, total_checks = 0, cyc = 0, i;
    logic [31:0] seed = 32'he860;
    logic [7:0] crc, d;
    logic       fb;

    sid_host_model host (.mclk(mclk), .sda(sda), .scl(scl),
        .sdaDrv(sdaDrv), .obs(obs));
    sid_i2c_slave #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER),
        .TIMEOUT_CYC(400)) dut (.mclk(mclk), .rst(rst), .sclIn(scl),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .smbusModeSelect(mode), .pointerValue(ptr), .busBusy(busy));

    always #2.5 mclk = ~mclk;
    // hang guard: whole run needs well under this many cycles
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            end_of_test;
        end
    end
    task automatic check(input string nm, input logic [8:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // each finished byte is compared with the oldest note
    always @(host.done) check("byte", obs, expQ.pop_front());
    task wr(input logic [7:0] b, input logic a);
        expQ.push_back({b, a});
        host.xfer(b, 1'b1);
    endtask
    task rd(input logic [7:0] b, input logic a);
        expQ.push_back({b, a});
        host.xfer(8'hff, a);
    endtask
    function logic [7:0] romb(input logic [3:0] k);
        if (k == 4'h8) return {7'h0, d[0]};
        if (k == 4'h7) return crc;
        return ROMW[8*k +: 8];
    endfunction
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        crc = 8'h0;
        for (i = 0; i < 56; i++)
        begin
            fb = crc[0] ^ ROMW[i];
            crc = (crc >> 1) ^ (fb ? 8'h8c : 8'h0);
        end
        repeat (10) @(posedge mclk);
        @(negedge mclk) rst = 1'b0;
        repeat (4) @(negedge mclk);
        check("ptr", ptr, 9'h0);
        check("mode", mode, 9'h1);
        $display("reset test done");
        host.start;
        wr(8'ha2, 1'b1);
        host.stop;
        host.start;
        wr(8'ha0, 1'b0);
        wr(8'h03, 1'b0);
        repeat (460) @(negedge mclk); // clock held low past the limit
        check("busy", busy, 9'h0);
        check("ptr", ptr, 9'h3);
        host.stop;
        $display("timeout test done");
        host.start;
        wr(8'ha0, 1'b0);
        wr(8'h09, 1'b1);
        host.stop;
        check("ptr", ptr, 9'h3);
        d = $random(seed);
        host.start;
        wr(8'ha0, 1'b0);
        wr(8'h08, 1'b0);
        wr(d, 1'b0);
        host.stop;
        check("mode", mode, {8'h0, d[0]});
        check("ptr", ptr, 9'h0);
        $display("write test done");
        host.start;
        wr(8'ha0, 1'b0);
        wr(8'h07, 1'b0);
        wr(d, 1'b1);
        host.start;
        wr(8'ha1, 1'b0);
        for (i = 0; i < 9; i++)
            rd(romb(4'((8 + i) % 9)), i == 8);
        host.stop;
        check("ptr", ptr, 9'h8);
        $display("read test done");
        end_of_test;
    end
endmodule // sid_i2c_slave_tb
